// File: hw/ies_event_sequencer.sv
`timescale 1ns/100ps
// Contract
// R1: address match sets event and match flags; status one read clears them.
// R2: slave received byte sets byte done; status one then data-in read clears.
// R3: slave sent byte sets byte done; status one then data-out write clears.
// R4: slave ack failure sets event, ack-fail, byte done, clock held low.
// R5: after ack failure, stop toggle or status one plus FFh write clears byte done.
// R6: lines released by stop toggle suppress the following stop event.
// R7: slave stop sets event and stop-seen; status two read clears them.
// R8: start sent sets start flag; status one then data-out write clears.
// R9: master address done sets only event; status one then control write clears.
// R10: master received byte sets byte done; status one then data-in read clears.
// R11: master acked byte sets byte done; status one then data-out write clears.
// R12: ten-bit header sent sets header flag; status one then data-out write clears.
// R13: receiver answers final byte with non-acknowledge; stop then follows.
// R14: every event sets summary flag; interrupt only while interrupt enable is one.
// R15: one interrupt line, needing enable and the unit unmask bit.
// R16: every event may wake from wait, never from halt.
// R17: arbitration loss and bus fault raise own flags under same enable.
// R18: clock held low while a transfer event awaits its clear sequence; code leaves it free while bus fault or arbitration loss is pending.
// R19: arbitration loss sets its flag and drops back to slave mode.
// R20: data or control access completes a clear only after a status one read.
`include "ies_defines.svh"
module ies_event_sequencer (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // link clock
  input wire logic clkLink,
  // link event pulses, one link clock wide
  input wire logic linkAddrMatch,
  input wire logic linkByteRx,
  input wire logic linkByteTx,
  input wire logic linkStartSent,
  input wire logic linkHeaderSent,
  input wire logic linkAddrSent,
  input wire logic linkAckFail,
  input wire logic linkStopSeen,
  input wire logic linkArbLost,
  input wire logic linkBusFault,
  // link control levels
  output logic linkSclHold,
  output logic linkRelease,
  output logic linkAckEnable,
  // processor access strobes
  input wire logic status1Rd,
  input wire logic status2Rd,
  input wire logic dataInRd,
  input wire logic dataOutWr,
  input wire logic [7:0] dataOutWrData,
  input wire logic controlWr,
  // control bits
  input wire logic irqEnable,
  input wire logic unitIrqUnmask,
  input wire logic stopCtrl,
  input wire logic ackCtrl,
  input wire logic cpuWaiting,
  input wire logic cpuHalted,
  // status and requests
  output logic [7:0] statusOne,
  output logic [7:0] statusTwo,
  output logic irqReq,
  output logic wakeReq
);

  // ========================================================================
  // event crossing from the link domain
  // ========================================================================
  logic [`IES_EV_COUNT-1:0] linkEvents;
  logic [`IES_EV_COUNT-1:0] evPulse;

  assign linkEvents[`IES_EV_ADDR_MATCH] = linkAddrMatch;
  assign linkEvents[`IES_EV_BYTE_RX] = linkByteRx;
  assign linkEvents[`IES_EV_BYTE_TX] = linkByteTx;
  assign linkEvents[`IES_EV_START_SENT] = linkStartSent;
  assign linkEvents[`IES_EV_HEADER_SENT] = linkHeaderSent;
  assign linkEvents[`IES_EV_ADDR_SENT] = linkAddrSent;
  assign linkEvents[`IES_EV_ACK_FAIL] = linkAckFail;
  assign linkEvents[`IES_EV_STOP_SEEN] = linkStopSeen;
  assign linkEvents[`IES_EV_ARB_LOST] = linkArbLost;
  assign linkEvents[`IES_EV_BUS_FAULT] = linkBusFault;

  ies_evt_cross #(
    .WIDTH(`IES_EV_COUNT)
  ) u_cross (
    .clkSrc(clkLink),
    .clkDst(clk_sys),
    .reset_n(reset_n),
    .srcPulse(linkEvents),
    .dstPulse(evPulse)
  );

  wire evAddrMatch = evPulse[`IES_EV_ADDR_MATCH];
  wire evByteRx = evPulse[`IES_EV_BYTE_RX];
  wire evByteTx = evPulse[`IES_EV_BYTE_TX];
  wire evStartSent = evPulse[`IES_EV_START_SENT];
  wire evHeaderSent = evPulse[`IES_EV_HEADER_SENT];
  wire evAddrSent = evPulse[`IES_EV_ADDR_SENT];
  wire evAckFail = evPulse[`IES_EV_ACK_FAIL];
  wire evStopSeen = evPulse[`IES_EV_STOP_SEEN];
  wire evArbLost = evPulse[`IES_EV_ARB_LOST];
  wire evBusFault = evPulse[`IES_EV_BUS_FAULT];

  // ========================================================================
  // state
  // ========================================================================
  ies_pkg::ies_seq_t seq_ff;
  ies_pkg::ies_seq_t nxt_seq;
  logic addrMatchFlag_ff;
  logic byteDoneFlag_ff;
  logic ackFailFlag_ff;
  logic stopSeenFlag_ff;
  logic startSentFlag_ff;
  logic headerSentFlag_ff;
  logic addrSentPend_ff;
  logic arbLostFlag_ff;
  logic busFaultFlag_ff;
  logic masterSelect_ff;
  logic transmit_ff;
  logic busy_ff;
  logic anyEventFlag_ff;
  logic stopCtrlLast_ff;
  logic stopArmed_ff;
  logic suppressStop_ff;
  logic releaseLines_ff;
  logic sclHold_ff;
  logic ackEnable_ff;
  logic irqReq_ff;
  logic wakeReq_ff;

  // ========================================================================
  // clear sequence decode
  // ========================================================================
  wire sr1Seen = (seq_ff == ies_pkg::IES_SEQ_SR1_READ);
  wire clearByRxRead = dataInRd & sr1Seen; // [R20]
  wire clearByTxWrite = dataOutWr & sr1Seen; // [R20]
  wire clearByCtrlWrite = controlWr & sr1Seen; // [R20]
  wire ffFill = (dataOutWrData == 8'hFF);
  wire stopRise = stopCtrl & ~stopCtrlLast_ff;
  wire stopFall = ~stopCtrl & stopCtrlLast_ff;
  wire releaseNow = stopFall & stopArmed_ff; // [R5]

  always_comb
  begin
    nxt_seq = seq_ff;
    case (seq_ff)
      ies_pkg::IES_SEQ_IDLE:
        if (status1Rd)
          nxt_seq = ies_pkg::IES_SEQ_SR1_READ;
      ies_pkg::IES_SEQ_SR1_READ:
        if (!status1Rd && (dataInRd | dataOutWr | controlWr))
          nxt_seq = ies_pkg::IES_SEQ_IDLE;
      default:
        nxt_seq = ies_pkg::IES_SEQ_IDLE;
    endcase
  end

  // ========================================================================
  // flag next values, set wins over clear
  // ========================================================================
  wire byteClearTx = clearByTxWrite & (~ackFailFlag_ff | ffFill); // [R3] [R5] [R11]
  wire byteClear = (transmit_ff ? byteClearTx : clearByRxRead) | releaseNow; // [R2] [R10]
  wire nxt_addrMatch = evAddrMatch | (addrMatchFlag_ff & ~status1Rd); // [R1]
  wire nxt_byteDone = evByteRx | evByteTx | evAckFail | (byteDoneFlag_ff & ~byteClear); // [R4]
  wire nxt_ackFail = evAckFail | (ackFailFlag_ff & ~status2Rd); // [R4]
  wire stopReport = evStopSeen & ~suppressStop_ff; // [R6]
  wire nxt_stopSeen = stopReport | (stopSeenFlag_ff & ~status2Rd); // [R7]
  wire nxt_startSent = evStartSent | (startSentFlag_ff & ~clearByTxWrite); // [R8]
  wire nxt_headerSent = evHeaderSent | (headerSentFlag_ff & ~clearByTxWrite); // [R12]
  wire nxt_addrSent = evAddrSent | (addrSentPend_ff & ~clearByCtrlWrite); // [R9]
  wire nxt_arbLost = evArbLost | (arbLostFlag_ff & ~status2Rd); // [R17] [R19]
  wire nxt_busFault = evBusFault | (busFaultFlag_ff & ~status2Rd); // [R17]

  wire nxt_anyEvent = nxt_addrMatch | nxt_byteDone | nxt_ackFail | nxt_stopSeen
    | nxt_startSent | nxt_headerSent | nxt_addrSent | nxt_arbLost | nxt_busFault; // [R14]

  // master from start sent until arbitration loss or stop
  wire nxt_master = evStartSent | (masterSelect_ff & ~evArbLost & ~evStopSeen); // [R19]

  wire nxt_transmit = evByteTx | evAckFail | (transmit_ff & ~evByteRx & ~evStopSeen
    & ~evArbLost & nxt_byteDone);

  wire nxt_busy = evAddrMatch | evStartSent | (busy_ff & ~evStopSeen);

  // bus fault and arbitration loss leave the clock free; ack failure keeps it low
  wire nxt_sclHold = (nxt_addrMatch | nxt_startSent | nxt_headerSent | nxt_addrSent
    | nxt_byteDone) & ~nxt_busFault & ~nxt_arbLost; // [R18] [R4]

  wire nxt_irqReq = nxt_anyEvent & irqEnable & unitIrqUnmask; // [R14] [R15] [R17]
  wire nxt_wakeReq = nxt_anyEvent & irqEnable & cpuWaiting & ~cpuHalted; // [R16]

  // stop toggle only releases while a byte is done
  wire nxt_stopArmed = (stopRise & byteDoneFlag_ff) | (stopArmed_ff & stopCtrl); // [R5]
  wire nxt_suppressStop = releaseNow | (suppressStop_ff & ~evStopSeen & ~evAddrMatch); // [R6]
  wire nxt_releaseLines = releaseNow | (releaseLines_ff & ~evAddrMatch & ~evStartSent);

  // ========================================================================
  // system domain registers
  // ========================================================================
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      seq_ff <= ies_pkg::IES_SEQ_IDLE;
      addrMatchFlag_ff <= 1'b0;
      byteDoneFlag_ff <= 1'b0;
      ackFailFlag_ff <= 1'b0;
      stopSeenFlag_ff <= 1'b0;
      startSentFlag_ff <= 1'b0;
      headerSentFlag_ff <= 1'b0;
      addrSentPend_ff <= 1'b0;
      arbLostFlag_ff <= 1'b0;
      busFaultFlag_ff <= 1'b0;
      anyEventFlag_ff <= 1'b0;
      masterSelect_ff <= 1'b0;
      transmit_ff <= 1'b0;
      busy_ff <= 1'b0;
      stopCtrlLast_ff <= 1'b0;
      stopArmed_ff <= 1'b0;
      suppressStop_ff <= 1'b0;
      releaseLines_ff <= 1'b0;
      sclHold_ff <= 1'b0;
      ackEnable_ff <= 1'b0;
      irqReq_ff <= 1'b0;
      wakeReq_ff <= 1'b0;
    end
    else
    begin
      seq_ff <= nxt_seq;
      addrMatchFlag_ff <= nxt_addrMatch;
      byteDoneFlag_ff <= nxt_byteDone;
      ackFailFlag_ff <= nxt_ackFail;
      stopSeenFlag_ff <= nxt_stopSeen;
      startSentFlag_ff <= nxt_startSent;
      headerSentFlag_ff <= nxt_headerSent;
      addrSentPend_ff <= nxt_addrSent;
      arbLostFlag_ff <= nxt_arbLost;
      busFaultFlag_ff <= nxt_busFault;
      anyEventFlag_ff <= nxt_anyEvent;
      masterSelect_ff <= nxt_master;
      transmit_ff <= nxt_transmit;
      busy_ff <= nxt_busy;
      stopCtrlLast_ff <= stopCtrl;
      stopArmed_ff <= nxt_stopArmed;
      suppressStop_ff <= nxt_suppressStop;
      releaseLines_ff <= nxt_releaseLines;
      sclHold_ff <= nxt_sclHold;
      ackEnable_ff <= ackCtrl; // [R13]
      irqReq_ff <= nxt_irqReq;
      wakeReq_ff <= nxt_wakeReq;
    end
  end

  // ========================================================================
  // status assembly
  // ========================================================================
  always_comb
  begin
    statusOne = `IES_STATUS_RST;
    statusOne[`IES_S1_ANY_EVENT] = anyEventFlag_ff;
    statusOne[`IES_S1_HEADER_SENT] = headerSentFlag_ff;
    statusOne[`IES_S1_TRANSMIT] = transmit_ff;
    statusOne[`IES_S1_BUSY] = busy_ff;
    statusOne[`IES_S1_BYTE_DONE] = byteDoneFlag_ff;
    statusOne[`IES_S1_ADDR_MATCH] = addrMatchFlag_ff;
    statusOne[`IES_S1_MASTER] = masterSelect_ff;
    statusOne[`IES_S1_START_SENT] = startSentFlag_ff;
  end

  always_comb
  begin
    statusTwo = `IES_STATUS_RST;
    statusTwo[`IES_S2_BUS_FAULT] = busFaultFlag_ff;
    statusTwo[`IES_S2_ARB_LOST] = arbLostFlag_ff;
    statusTwo[`IES_S2_STOP_SEEN] = stopSeenFlag_ff;
    statusTwo[`IES_S2_ACK_FAIL] = ackFailFlag_ff;
  end

  assign irqReq = irqReq_ff;
  assign wakeReq = wakeReq_ff;

  // ========================================================================
  // level crossing to the link domain
  // ========================================================================
  logic [2:0] levelMeta_ff;
  logic [2:0] levelSync_ff;
  wire [2:0] levelSrc = {ackEnable_ff, releaseLines_ff, sclHold_ff};

  always_ff @(posedge clkLink or negedge reset_n)
  begin
    if (!reset_n)
    begin
      levelMeta_ff <= `IES_LEVEL_RST;
      levelSync_ff <= `IES_LEVEL_RST;
    end
    else
    begin
      levelMeta_ff <= levelSrc;
      levelSync_ff <= levelMeta_ff;
    end
  end

  assign linkSclHold = levelSync_ff[0]; // [R18] [R4]
  assign linkRelease = levelSync_ff[1]; // [R5]
  assign linkAckEnable = levelSync_ff[2]; // [R13]

endmodule : ies_event_sequencer

// File: hw/ies_defines.svh
`ifndef IES_DEFINES_SVH
`define IES_DEFINES_SVH

// ==========================================================================
// link event positions inside the crossed event vector
// ==========================================================================
`define IES_EV_COUNT 10
`define IES_EV_ADDR_MATCH 0
`define IES_EV_BYTE_RX 1
`define IES_EV_BYTE_TX 2
`define IES_EV_START_SENT 3
`define IES_EV_HEADER_SENT 4
`define IES_EV_ADDR_SENT 5
`define IES_EV_ACK_FAIL 6
`define IES_EV_STOP_SEEN 7
`define IES_EV_ARB_LOST 8
`define IES_EV_BUS_FAULT 9

// ==========================================================================
// status one field positions
// ==========================================================================
`define IES_S1_ANY_EVENT 7
`define IES_S1_HEADER_SENT 6
`define IES_S1_TRANSMIT 5
`define IES_S1_BUSY 4
`define IES_S1_BYTE_DONE 3
`define IES_S1_ADDR_MATCH 2
`define IES_S1_MASTER 1
`define IES_S1_START_SENT 0

// ==========================================================================
// status two field positions
// ==========================================================================
`define IES_S2_BUS_FAULT 1
`define IES_S2_ARB_LOST 2
`define IES_S2_STOP_SEEN 3
`define IES_S2_ACK_FAIL 4

// ==========================================================================
// reset values
// ==========================================================================
`define IES_STATUS_RST 8'h00
`define IES_LEVEL_RST 3'h0

`endif

// File: hw/ies_pkg.sv
package ies_pkg;

  // clear sequence tracker: has status one been read
  typedef enum logic [0:0] {
    IES_SEQ_IDLE,
    IES_SEQ_SR1_READ
  } ies_seq_t;

endpackage : ies_pkg

// File: hw/ies_evt_cross.sv
`timescale 1ns/100ps
// ==========================================================================
// toggle crossing for one-cycle event pulses
// ==========================================================================
module ies_evt_cross #(
  parameter int WIDTH = 10
) (
  // clocks and reset
  input wire logic clkSrc,
  input wire logic clkDst,
  input wire logic reset_n,
  // source side pulses
  input wire logic [WIDTH-1:0] srcPulse,
  // destination side pulses
  output logic [WIDTH-1:0] dstPulse
);

  logic [WIDTH-1:0] srcToggle_ff;
  logic [WIDTH-1:0] syncMeta_ff;
  logic [WIDTH-1:0] syncStable_ff;
  logic [WIDTH-1:0] syncLast_ff;
  logic [WIDTH-1:0] nxt_dstPulse;

  // toggle is a level, so a stopped source clock loses nothing
  always_ff @(posedge clkSrc or negedge reset_n)
  begin
    if (!reset_n)
      srcToggle_ff <= '0;
    else
      srcToggle_ff <= srcToggle_ff ^ srcPulse;
  end

  assign nxt_dstPulse = syncStable_ff ^ syncLast_ff;

  always_ff @(posedge clkDst or negedge reset_n)
  begin
    if (!reset_n)
    begin
      syncMeta_ff <= '0;
      syncStable_ff <= '0;
      syncLast_ff <= '0;
      dstPulse <= '0;
    end
    else
    begin
      syncMeta_ff <= srcToggle_ff;
      syncStable_ff <= syncMeta_ff;
      syncLast_ff <= syncStable_ff;
      dstPulse <= nxt_dstPulse;
    end
  end

endmodule : ies_evt_cross

// File: verification/ies_event_sequencer_assertions.sv
`timescale 1ns/100ps
// ==========================================================================
// event sequencer checker
// ==========================================================================
module ies_event_sequencer_assertions (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // accesses and levels
  input wire logic status1Rd,
  input wire logic status2Rd,
  input wire logic dataInRd,
  input wire logic dataOutWr,
  input wire logic [7:0] dataOutWrData,
  input wire logic controlWr,
  input wire logic irqEnable,
  input wire logic unitIrqUnmask,
  input wire logic cpuWaiting,
  input wire logic cpuHalted,
  // status and requests
  input wire logic [7:0] statusOne,
  input wire logic [7:0] statusTwo,
  input wire logic irqReq,
  input wire logic wakeReq
);
  logic sr1Seen_ff;
  logic nxt_sr1Seen;
  logic follow;
  assign follow = dataInRd | dataOutWr | controlWr;
  assign nxt_sr1Seen = status1Rd | (sr1Seen_ff & ~follow);
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      sr1Seen_ff <= 1'b0;
    else
      sr1Seen_ff <= nxt_sr1Seen;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_irqGate;
    irqReq == (statusOne[7] && $past(irqEnable) && $past(unitIrqUnmask));
  endproperty
  a_irqGate: assert property (p_irqGate) else $error("irq level wrong");
  property p_wakeGate;
    wakeReq == (statusOne[7] && $past(irqEnable) && $past(cpuWaiting) && !$past(cpuHalted));
  endproperty
  a_wakeGate: assert property (p_wakeGate) else $error("wake level wrong");
  property p_matchSet;
    $rose(statusOne[2]) |-> statusOne[7];
  endproperty
  a_matchSet: assert property (p_matchSet) else $error("match without event");
  property p_matchClr;
    statusOne[2] && status1Rd |=> !statusOne[2];
  endproperty
  a_matchClr: assert property (p_matchClr) else $error("match not cleared");
  property p_rxClr;
    statusOne[3] && !statusOne[5] && sr1Seen_ff && dataInRd |=> !statusOne[3];
  endproperty
  a_rxClr: assert property (p_rxClr) else $error("rx byte not cleared");
  property p_txClr;
    statusOne[3] && statusOne[5] && !statusTwo[4] && sr1Seen_ff && dataOutWr |=> !statusOne[3];
  endproperty
  a_txClr: assert property (p_txClr) else $error("tx byte not cleared");
  property p_noPair;
    statusOne[3] && !sr1Seen_ff && (dataInRd || dataOutWr) |=> statusOne[3];
  endproperty
  a_noPair: assert property (p_noPair) else $error("clear without status read");
  property p_ackKeep;
    statusOne[3] && statusTwo[4] && dataOutWr && dataOutWrData != 8'hff |=> statusOne[3];
  endproperty
  a_ackKeep: assert property (p_ackKeep) else $error("byte done lost");
  property p_stat2Clr;
    status2Rd |=> statusTwo[4:1] == 4'h0;
  endproperty
  a_stat2Clr: assert property (p_stat2Clr) else $error("status two kept");
  property p_arbLost;
    $rose(statusTwo[2]) |-> statusOne[7] ##1 !statusOne[1];
  endproperty
  a_arbLost: assert property (p_arbLost) else $error("arb loss handling");
endmodule : ies_event_sequencer_assertions

bind ies_event_sequencer ies_event_sequencer_assertions i_ies_event_sequencer_assertions (
  .clk_sys, .reset_n, .status1Rd, .status2Rd, .dataInRd, .dataOutWr, .dataOutWrData,
  .controlWr, .irqEnable, .unitIrqUnmask, .cpuWaiting, .cpuHalted, .statusOne,
  .statusTwo, .irqReq, .wakeReq
);

// File: verification/ies_bus_model.sv
`timescale 1ns/100ps
// ==========================================================================
// bus engine model, link clock runs only inside frames
// ==========================================================================
module ies_bus_model (
  // link clock
  output logic clkLink,
  // link event pulses
  output logic linkAddrMatch,
  output logic linkByteRx,
  output logic linkByteTx,
  output logic linkStartSent,
  output logic linkHeaderSent,
  output logic linkAddrSent,
  output logic linkAckFail,
  output logic linkStopSeen,
  output logic linkArbLost,
  output logic linkBusFault
);
  logic [9:0] linkEv;
  assign {linkBusFault, linkArbLost, linkStopSeen, linkAckFail, linkAddrSent, linkHeaderSent,
    linkStartSent, linkByteTx, linkByteRx, linkAddrMatch} = linkEv;
  initial
  begin
    clkLink = 1'b0;
    linkEv = 10'h000;
  end
  task idle(input int n);
    repeat (n)
    begin
      #7.5 clkLink = 1'b1;
      #7.5 clkLink = 1'b0;
    end
  endtask : idle
  // one pulse held across exactly one rising edge
  task fire(input int idx);
    idle(2);
    #7.5 clkLink = 1'b1;
    #1 linkEv = 10'h001 << idx;
    #6.5 clkLink = 1'b0;
    #7.5 clkLink = 1'b1;
    #1 linkEv = 10'h000;
    #6.5 clkLink = 1'b0;
    idle(8);
  endtask : fire
endmodule : ies_bus_model

// File: verification/ies_event_sequencer_tb_top.sv
`timescale 1ns/100ps
// ==========================================================================
// event sequencer bench
// ==========================================================================
module ies_event_sequencer_tb_top;
  typedef struct {int ev; int clr; logic [7:0] m1; logic [7:0] e1; logic [7:0] m2;} ies_row_t;
  logic clk_sys, reset_n, clkLink, stopCtrl, irqEnable, unitIrqUnmask, cpuWaiting, cpuHalted;
  logic linkSclHold, linkRelease, linkAckEnable, irqReq, wakeReq, ackCtrl;
  wire linkAddrMatch, linkByteRx, linkByteTx, linkStartSent, linkHeaderSent, linkAddrSent;
  wire linkAckFail, linkStopSeen, linkArbLost, linkBusFault;
  logic [4:0] strb;
  logic [7:0] wrData, statusOne, statusTwo;
  int fails, checksDone;
  ies_row_t rows [9] = '{'{0, 0, 8'h84, 8'h84, 8'h00}, '{1, 1, 8'hac, 8'h88, 8'h00},
    '{2, 2, 8'hac, 8'ha8, 8'h00}, '{3, 2, 8'h83, 8'h83, 8'h00}, '{4, 2, 8'hc0, 8'hc0, 8'h00},
    '{5, 3, 8'hcd, 8'h80, 8'h00}, '{8, 4, 8'h82, 8'h80, 8'h04}, '{9, 4, 8'h80, 8'h80, 8'h02},
    '{7, 4, 8'h80, 8'h80, 8'h08}};
  logic [3:0] lv [3] = '{4'h6, 4'ha, 4'hf};
  logic [7:0] lvExp [3] = '{8'h00, 8'h01, 8'h02};

  ies_event_sequencer i_ies_event_sequencer (
    .clk_sys(clk_sys), .reset_n(reset_n), .clkLink(clkLink),
    .linkAddrMatch(linkAddrMatch), .linkByteRx(linkByteRx), .linkByteTx(linkByteTx),
    .linkStartSent(linkStartSent), .linkHeaderSent(linkHeaderSent),
    .linkAddrSent(linkAddrSent), .linkAckFail(linkAckFail), .linkStopSeen(linkStopSeen),
    .linkArbLost(linkArbLost), .linkBusFault(linkBusFault), .linkSclHold(linkSclHold),
    .linkRelease(linkRelease), .linkAckEnable(linkAckEnable), .status1Rd(strb[0]),
    .status2Rd(strb[1]), .dataInRd(strb[2]), .dataOutWr(strb[3]), .dataOutWrData(wrData),
    .controlWr(strb[4]), .irqEnable(irqEnable), .unitIrqUnmask(unitIrqUnmask),
    .stopCtrl(stopCtrl), .ackCtrl(ackCtrl), .cpuWaiting(cpuWaiting), .cpuHalted(cpuHalted),
    .statusOne(statusOne), .statusTwo(statusTwo), .irqReq(irqReq), .wakeReq(wakeReq));
  ies_bus_model i_ies_bus_model (
    .clkLink(clkLink), .linkAddrMatch(linkAddrMatch), .linkByteRx(linkByteRx),
    .linkByteTx(linkByteTx), .linkStartSent(linkStartSent), .linkHeaderSent(linkHeaderSent),
    .linkAddrSent(linkAddrSent), .linkAckFail(linkAckFail), .linkStopSeen(linkStopSeen),
    .linkArbLost(linkArbLost), .linkBusFault(linkBusFault));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  // strobe order: status one, status two, data in, data out, control
  task acc(input int k, input logic [7:0] d);
    @(negedge clk_sys);
    strb = 5'h01 << k;
    wrData = d;
    @(negedge clk_sys);
    strb = 5'h00;
  endtask : acc
  task clr(input int k);
    if (k < 4)
      acc(0, 8'h00);
    if (k > 0)
      acc(k == 4 ? 1 : k + 1, 8'h5a);
  endtask : clr
  task end_of_test;
    if (fails == 0 && checksDone > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    #100000;
    fails++;
    end_of_test;
  end
  initial
  begin
    {reset_n, strb, wrData, stopCtrl, cpuHalted, fails, checksDone} = '0;
    {irqEnable, unitIrqUnmask, cpuWaiting, ackCtrl} = 4'hf;
    repeat (5) @(negedge clk_sys);
    chk("reset", statusOne | statusTwo
      | {3'h0, linkSclHold, linkAckEnable, linkRelease, irqReq, wakeReq}, 8'h00);
    reset_n = 1'b1;
    foreach (rows[i])
    begin
      i_ies_bus_model.fire(rows[i].ev);
      chk("status one", statusOne & rows[i].m1, rows[i].e1);
      chk("status two", statusTwo & rows[i].m2, rows[i].m2);
      chk("irq wake", {6'h00, irqReq, wakeReq}, 8'h03);
      if (rows[i].clr < 4)
        chk("scl hold", {7'h00, linkSclHold}, 8'h01);
      clr(rows[i].clr);
      chk("cleared", (statusOne & rows[i].m1 & 8'hfd) | (statusTwo & rows[i].m2)
        | {7'h00, irqReq}, 8'h00);
      i_ies_bus_model.idle(3);
      chk("scl free", {7'h00, linkSclHold}, 8'h00);
    end
    i_ies_bus_model.fire(1);
    acc(2, 8'h00);
    chk("unpaired read", statusOne & 8'h88, 8'h88);
    clr(1);
    chk("paired read", statusOne & 8'h88, 8'h00);
    // remote receiver withholds ack on its last byte
    i_ies_bus_model.fire(6);
    chk("ack fail s1", statusOne & 8'h88, 8'h88);
    chk("ack fail s2", statusTwo & 8'h10, 8'h10);
    chk("ack fail hold", {7'h00, linkSclHold}, 8'h01);
    clr(2);
    chk("wrong fill", statusOne & 8'h08, 8'h08);
    acc(0, 8'h00);
    acc(3, 8'hff);
    chk("fill clears", statusOne & 8'h08, 8'h00);
    acc(1, 8'h00);
    chk("ack fail clr", (statusTwo & 8'h10) | (statusOne & 8'h80), 8'h00);
    i_ies_bus_model.fire(6);
    acc(1, 8'h00);
    @(negedge clk_sys);
    stopCtrl = 1'b1;
    repeat (2) @(negedge clk_sys);
    stopCtrl = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("toggle clears", statusOne & 8'h08, 8'h00);
    i_ies_bus_model.idle(3);
    chk("released", {7'h00, linkRelease}, 8'h01);
    i_ies_bus_model.fire(7);
    chk("stop hidden", statusTwo & 8'h08, 8'h00);
    i_ies_bus_model.fire(7);
    chk("stop seen", statusTwo & 8'h08, 8'h08);
    acc(1, 8'h00);
    i_ies_bus_model.fire(0);
    for (int j = 0; j < 3; j++)
    begin
      @(negedge clk_sys);
      {irqEnable, unitIrqUnmask, cpuWaiting, cpuHalted} = lv[j];
      repeat (2) @(negedge clk_sys);
      chk("gating", {6'h00, irqReq, wakeReq}, lvExp[j]);
    end
    acc(0, 8'h00);
    chk("match clr", statusOne & 8'h84, 8'h00);
    chk("ack on", {7'h00, linkAckEnable}, 8'h01);
    ackCtrl = 1'b0;
    i_ies_bus_model.idle(3);
    chk("ack off", {7'h00, linkAckEnable}, 8'h00);
    end_of_test;
  end
endmodule : ies_event_sequencer_tb_top
